// file: design/pbcs_top.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - multiplier zero behaves like multiplier one
// - range zero disables loop, forces crystal
// - switch waits three crystal edges, and three vco edges if loop enabled
// - selected clock halved for even duty
// - select ignored while loop power off
// - power-off ignored while vco selected
// - power then select needs two writes
// - oscillator and loop run only when enabled
// - irq when flag and enable both set, in auto mode and without stop
// - enable unwritable, reads zero in manual
// - flag sets on every lock toggle
// - flag reads zero in manual mode
// - reading control register clears flag
// - reset turns loop power on
// - select one picks vco, reset clears
// - low four control bits read ones
// - bandwidth mode bit, reset manual
// - lock reads locked in auto, zero manual
// - stop clears select, crystal after wake
module pbcs_top
    import pbcs_pkg::*;
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // source clocks, sampled as data
    input  wire logic        xtal_clk,
    input  wire logic        vco_clk,
    // system integration and lock detector
    input  wire logic        osc_enable_in,
    input  wire logic        stop_in,
    input  wire logic        vco_locked_in,
    // clock outputs and controls
    output logic             base_clk,
    output logic             loop_irq,
    output logic             osc_run,
    output logic             loop_enable,
    output logic      [3:0]  mult_eff,
    output logic      [3:0]  range_eff
);

    // how the block is meant to be used
    //
    // bus side
    // - every transfer is answered after one wait state
    // - pready and pslverr stand for one cycle only; prdata holds until the next answer
    // - the answer is registered, so prdata never glitches
    // - upper 24 data bits read zero and are ignored on write
    // - unmapped offsets answer with zero data and an error
    // - back to back transfers are accepted
    //
    // control register
    // - irq enable only writable in automatic mode
    // - irq enable and change flag masked when manual
    // - power-off refused while the vco is selected
    // - select judged against the power bit before the write
    // - so selecting the vco from power-off needs two writes
    // - low four bits have no storage and read as ones
    // - any control read clears the change flag
    // - a flag set in the same cycle as the read survives
    //   (losing a lock event is worse than a spare interrupt)
    //
    // bandwidth register
    // - mode bit selects automatic or manual control
    // - lock indicator only meaningful in automatic mode
    // - acquisition bit lives outside this block
    //
    // programming register
    // - multiplier and range writable only with loop power off
    // - multiplier zero is shown as one downstream
    // - range zero keeps the loop off and the crystal chosen
    //
    // transition circuit
    // - source clocks are sampled as data by pclk
    // - each source must stay slower than a quarter of pclk
    // - three flops per source; edges seen on the last two
    // - base clock toggles once per chosen source rising edge
    // - toggling per edge gives an even duty whatever the source
    // - on a select change the output freezes at its level
    // - three crystal and three vco edges are counted first
    // - a powered-down vco is not waited for, or we would hang
    // - the counters saturate, so late edges cannot wrap them
    // - the new source takes over only from the run state
    // - limitation: output edges lag the source by 2-3 cycles
    //
    // stop
    // - stop drops the vco selection at the next edge
    // - stop holds the base clock and the interrupt low
    // - after stop the crystal drives the output again
    //
    // oscillator gating
    // - oscillator runs only while the system enables it
    // - loop enable also needs power on and a non-zero range
    //
    // reset
    // - loop power comes up on so it can settle early
    // - selection, mode, enable and flag come up clear
    // - multiplier and range come up at their defaults
    // - the transition circuit starts on the crystal
    //
    // trade-offs
    // - one packed state keeps every register in one process
    // - derived levels stay combinational to save flops
    // - the interrupt is a level, cleared only by a read
    // - no interrupt logic beyond the flag, enable, mode and stop gate

    pbcs_state_s st_reg;     // all state
    pbcs_state_s st_next;    // next state
    logic        range_ok;   // range field non-zero
    logic        lock_bit;   // visible lock indicator
    logic        sel_eff;    // effective vco selection
    logic        xedge;      // crystal rising edge
    logic        vedge;      // vco rising edge
    logic        wr_done;    // write completes this edge
    logic        rd_done;    // read completes this edge

    // readback of control register with masking
    function automatic logic [7:0] ctrl_view(input pbcs_regs_s r);
        ctrl_view = {r.irq_en & r.bw_auto,
                     r.change_flag & r.bw_auto,
                     r.power_on,
                     r.base_src,
                     CTRL_UNUSED};
    endfunction

    // derived levels
    always_comb
    begin
        range_ok    = (st_reg.regs.vrs != 4'h0);
        // lock only meaningful in auto mode
        lock_bit    = st_reg.regs.bw_auto & vco_locked_in;
        sel_eff     = st_reg.regs.base_src & range_ok;
        // edge detect on second and third stage only
        xedge       = st_reg.xs[1] & ~st_reg.xs[2];
        vedge       = st_reg.vs[1] & ~st_reg.vs[2];
        wr_done     = psel & penable & st_reg.ack & pwrite;
        rd_done     = psel & penable & st_reg.ack & ~pwrite;
        osc_run     = osc_enable_in;
        loop_enable = st_reg.regs.power_on & osc_enable_in & range_ok;
        mult_eff    = (st_reg.regs.mul == 4'h0) ? 4'h1 : st_reg.regs.mul;
        range_eff   = st_reg.regs.vrs;
        prdata      = st_reg.rdata;
        pready      = st_reg.ack;
        pslverr     = st_reg.ack & st_reg.slverr;
        base_clk    = st_reg.base_clk;
        // stop holds the interrupt low
        loop_irq    = st_reg.regs.change_flag & st_reg.regs.irq_en
                      & st_reg.regs.bw_auto & ~stop_in;
    end

    // next state: bus, registers, transition circuit
    always_comb
    begin
        st_next = st_reg;

        // three-stage sampling of each source clock
        st_next.xs = {st_reg.xs[1:0], xtal_clk};
        st_next.vs = {st_reg.vs[1:0], vco_clk};

        // apb: one wait state, answer registered
        st_next.ack = psel & penable & ~st_reg.ack;
        if (psel && penable && !st_reg.ack)
        begin
            st_next.slverr = 1'b0;
            unique case (paddr)
                CTRL_OFS:  st_next.rdata = {24'h0, ctrl_view(st_reg.regs)};
                BW_OFS:    st_next.rdata = {24'h0, st_reg.regs.bw_auto, lock_bit, 6'h00};
                PROG_OFS:  st_next.rdata = {24'h0, st_reg.regs.mul, st_reg.regs.vrs};
                default:
                begin
                    // unmapped: zero data and an error
                    st_next.rdata  = 32'h0;
                    st_next.slverr = 1'b1;
                end
            endcase
        end

        // register writes take effect when pready is seen
        // writing one cycle late keeps the data and the
        // answer aligned with the edge the master samples
        if (wr_done)
        begin
            unique case (paddr)
                CTRL_OFS:
                begin
                    // enable only writable in auto mode
                    if (st_reg.regs.bw_auto)
                    begin
                        st_next.regs.irq_en = pwdata[CTRL_IE_BIT];
                    end
                    // power-off refused while vco selected
                    if (!(st_reg.regs.base_src && !pwdata[CTRL_ON_BIT]))
                    begin
                        st_next.regs.power_on = pwdata[CTRL_ON_BIT];
                    end
                    // select judged against old power bit, so two writes
                    if (st_reg.regs.power_on)
                    begin
                        st_next.regs.base_src = pwdata[CTRL_SEL_BIT];
                    end
                    else
                    begin
                        st_next.regs.base_src = 1'b0;
                    end
                end
                BW_OFS:
                begin
                    st_next.regs.bw_auto = pwdata[BW_AUTO_BIT];
                end
                PROG_OFS:
                begin
                    // protected while the loop is powered
                    if (!st_reg.regs.power_on)
                    begin
                        st_next.regs.mul = pwdata[7:4];
                        st_next.regs.vrs = pwdata[3:0];
                    end
                end
                default:
                begin
                    // unmapped write ignored
                    st_next.regs = st_reg.regs;
                end
            endcase
        end

        // any control read clears the flag
        if (rd_done && paddr == CTRL_OFS)
        begin
            st_next.regs.change_flag = 1'b0;
        end

        // lock toggle sets flag; set beats the read clear
        st_next.lock_prev = lock_bit;
        if (lock_bit != st_reg.lock_prev)
        begin
            st_next.regs.change_flag = 1'b1;
        end

        // zero range and stop both drop the vco selection
        if (!range_ok || stop_in)
        begin
            st_next.regs.base_src = 1'b0;
        end

        // transition circuit
        // run: follow the current source edge by edge
        // wait: hold the level and count edges of both
        // the output is a flop, so it cannot show a runt
        // pulse even if a source glitches mid-switch
        unique case (st_reg.tr)
            TR_RUN:
            begin
                if (sel_eff != st_reg.cur_vco)
                begin
                    st_next.tr   = TR_WAIT;
                    st_next.xcnt = 2'h0;
                    st_next.vcnt = 2'h0;
                end
                else if (st_reg.cur_vco ? vedge : xedge)
                begin
                    st_next.base_clk = ~st_reg.base_clk;
                end
            end
            TR_WAIT:
            begin
                // output held static while edges are counted
                if (xedge && st_reg.xcnt != SWITCH_EDGES)
                begin
                    st_next.xcnt = st_reg.xcnt + 2'h1;
                end
                if (vedge && st_reg.vcnt != SWITCH_EDGES)
                begin
                    st_next.vcnt = st_reg.vcnt + 2'h1;
                end
                // a stopped vco cannot count; crystal alone decides then
                if (st_reg.xcnt == SWITCH_EDGES
                    && (st_reg.vcnt == SWITCH_EDGES || !loop_enable))
                begin
                    st_next.tr      = TR_RUN;
                    st_next.cur_vco = sel_eff;
                end
            end
        endcase

        // stop holds the base clock low
        if (stop_in)
        begin
            st_next.base_clk = 1'b0;
        end
    end

    // state register
    // reset branch holds constants only, so the
    // asynchronous path never depends on bus inputs;
    // every field not named below comes up as zero,
    // which covers the answer, the flag, the enable,
    // the synchronisers, both counters and the output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg                  <= '0;
            st_reg.regs.power_on    <= 1'b1;
            st_reg.regs.base_src    <= 1'b0;
            st_reg.regs.bw_auto     <= 1'b0;
            st_reg.regs.mul         <= MUL_RST;
            st_reg.regs.vrs         <= VRS_RST;
            st_reg.tr               <= TR_RUN;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

endmodule

// file: design/pbcs_pkg.sv
package pbcs_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] BW_OFS        = 8'h04;
    localparam logic [7:0] PROG_OFS      = 8'h08;

    // control register field positions
    localparam int         CTRL_IE_BIT   = 7;
    localparam int         CTRL_FLAG_BIT = 6;
    localparam int         CTRL_ON_BIT   = 5;
    localparam int         CTRL_SEL_BIT  = 4;
    localparam logic [3:0] CTRL_UNUSED   = 4'hf;

    // bandwidth register field positions
    localparam int         BW_AUTO_BIT   = 7;
    localparam int         BW_LOCK_BIT   = 6;

    // programming register reset: multiplier 6, range 6
    localparam logic [3:0] MUL_RST       = 4'h6;
    localparam logic [3:0] VRS_RST       = 4'h6;

    // source edges waited for during a switch-over
    localparam logic [1:0] SWITCH_EDGES  = 2'h3;

    // transition circuit states
    typedef enum logic [0:0] {
        TR_RUN  = 1'b0,
        TR_WAIT = 1'b1
    } pbcs_tr_e;

    // software visible control bits
    typedef struct packed {
        logic       irq_en;
        logic       change_flag;
        logic       power_on;
        logic       base_src;
        logic       bw_auto;
        logic [3:0] mul;
        logic [3:0] vrs;
    } pbcs_regs_s;

    // whole block state
    typedef struct packed {
        pbcs_regs_s  regs;
        logic        ack;
        logic [31:0] rdata;
        logic        slverr;
        logic        lock_prev;
        logic [2:0]  xs;
        logic [2:0]  vs;
        pbcs_tr_e    tr;
        logic        cur_vco;
        logic [1:0]  xcnt;
        logic [1:0]  vcnt;
        logic        base_clk;
    } pbcs_state_s;

endpackage

// file: dv/pbcs_asserts.sv
`timescale 1ns/100ps
module pbcs_asserts
    import pbcs_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // system side and outputs
    input wire logic        osc_enable_in,
    input wire logic        stop_in,
    input wire logic        base_clk,
    input wire logic        loop_irq,
    input wire logic        osc_run,
    input wire logic        loop_enable,
    input wire logic [3:0]  mult_eff,
    input wire logic [3:0]  range_eff
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // read answers, and addresses outside the map
    wire rd_ctl = pready && !pwrite && paddr == CTRL_OFS;
    wire rd_bw  = pready && !pwrite && paddr == BW_OFS;
    wire unmap  = paddr != CTRL_OFS && paddr != BW_OFS && paddr != PROG_OFS;
    chk_mult_nonzero: assert property (mult_eff != 4'h0)
        else $error("multiplier shown as zero");
    chk_loop_gate: assert property (loop_enable |-> osc_enable_in && range_eff != 4'h0)
        else $error("loop enabled while gated");
    chk_osc_follow: assert property (osc_run == osc_enable_in)
        else $error("oscillator run differs from enable");
    // one wait state, then a single-cycle answer
    chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
        else $error("apb answer timing wrong");
    chk_low_ones: assert property (rd_ctl |-> prdata[3:0] == CTRL_UNUSED)
        else $error("control low bits not ones");
    chk_lock_manual: assert property (rd_bw && prdata[BW_LOCK_BIT] |-> prdata[BW_AUTO_BIT])
        else $error("lock read high in manual mode");
    // stop holds clock and irq low once it has been seen
    chk_stop_low: assert property (stop_in ##1 stop_in |-> !base_clk && !loop_irq)
        else $error("outputs not low during stop");
    chk_err_map: assert property (pready |-> pslverr == unmap)
        else $error("slave error does not match map");
    cover property (loop_irq);
    cover property (rd_ctl && prdata[CTRL_FLAG_BIT]);
    cover property (pready && pslverr);
    cover property ($rose(base_clk));
endmodule

bind pbcs_top pbcs_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .osc_enable_in, .stop_in, .base_clk, .loop_irq, .osc_run, .loop_enable,
    .mult_eff, .range_eff);

// file: dv/pbcs_partner.sv
`timescale 1ns/100ps
module pbcs_partner
(
    // bench clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // block controls and noise hit
    input wire logic osc_run,
    input wire logic loop_enable,
    input wire logic hit,
    // sources and lock detector
    output logic     xtal_clk,
    output logic     vco_clk,
    output logic     vco_locked_in
);
    logic [3:0] xc_reg; // crystal phase, period 10
    logic [2:0] vc_reg; // vco phase, period 6
    logic [5:0] lc_reg; // settle time before lock
    // sources stay slower than pclk/4; a stopped source stands low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xc_reg <= 4'h0;
            vc_reg <= 3'h0;
            lc_reg <= 6'h00;
        end
        else
        begin
            xc_reg <= (!osc_run || xc_reg == 4'h9) ? 4'h0 : xc_reg + 4'h1;
            vc_reg <= (!loop_enable || vc_reg == 3'h5) ? 3'h0 : vc_reg + 3'h1;
            lc_reg <= (!loop_enable || hit) ? 6'h00 : lc_reg + {5'h0, lc_reg != 6'h28};
        end
    end
    // half high, half low; a hit drops lock at once
    assign xtal_clk      = osc_run && xc_reg < 4'h5;
    assign vco_clk       = loop_enable && vc_reg < 3'h3;
    assign vco_locked_in = lc_reg == 6'h28;
endmodule

// file: dv/pbcs_top_tb.sv
`timescale 1ns/100ps
module pbcs_top_tb
    import pbcs_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, osc_enable_in, stop_in, hit;
    logic        pready, pslverr, xtal_clk, vco_clk, vco_locked_in, base_clk, loop_irq;
    logic        osc_run, loop_enable;
    logic [7:0]  paddr, ra;
    logic [31:0] pwdata, prdata;
    logic [3:0]  mult_eff, range_eff;
    logic [31:0] qd[$]; // expected read words
    logic        qw[$], qe[$]; // direction and expected error
    int          num_errors = 0, total_checks = 0, seed = 32'hb87f, k;
    // write flag, address, data, expected read byte
    logic [24:0] tbl [20] = '{25'h0_00_00_2f,
        25'h0_04_00_00, 25'h1_00_00_00, 25'h1_08_05_00,
        25'h0_08_00_05, 25'h1_00_30_00, 25'h0_00_00_2f,
        25'h1_00_30_00, 25'h0_00_00_3f, 25'h1_00_00_00,
        25'h0_00_00_2f, 25'h1_00_00_00, 25'h1_08_60_00,
        25'h1_00_20_00, 25'h1_00_30_00, 25'h0_00_00_2f,
        25'h1_00_00_00, 25'h1_08_66_00, 25'h1_00_a0_00, 25'h0_00_00_2f};
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    pbcs_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .xtal_clk, .vco_clk, .osc_enable_in, .stop_in, .vco_locked_in,
        .base_clk, .loop_irq, .osc_run, .loop_enable, .mult_eff, .range_eff);
    pbcs_partner u_far (.pclk, .presetn, .osc_run, .loop_enable, .hit, .xtal_clk, .vco_clk,
        .vco_locked_in);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer; the note goes in before the request starts
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [7:0] e, input logic er);
        int n;
        n = 0;
        qd.push_back({24'h0, e});
        qw.push_back(w);
        qe.push_back(er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40)
        begin
            num_errors++;
            final_report();
        end
        @(posedge pclk);
    endtask
    // rising edges and high time of base_clk over 240 cycles
    task automatic meas(input string n, input int per);
        int r, h;
        logic p;
        r = 0;
        h = 0;
        p = base_clk;
        repeat (240)
        begin
            @(posedge pclk);
            r += (base_clk === 1'b1 && p === 1'b0);
            h += (base_clk === 1'b1);
            p = base_clk;
        end
        chk({n, " rate"}, 32'h1, {31'h0, r >= 120 / per - 1 && r <= 120 / per + 1});
        chk({n, " duty"}, 32'h1, {31'h0, h >= 120 - per && h <= 120 + per});
    endtask
    // answer watcher: oldest note against each pready
    always @(posedge pclk)
    begin
        if (pready === 1'b1 && qd.size() > 0)
        begin
            if (!qw[0] && !qe[0])
                chk("prdata", qd.pop_front(), prdata);
            else
                void'(qd.pop_front());
            chk("pslverr", {31'h0, qe.pop_front()}, {31'h0, pslverr});
            void'(qw.pop_front());
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, stop_in, hit, paddr, pwdata} = '0;
        osc_enable_in = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (tbl[i])
        begin
            apb(tbl[i][24], tbl[i][23:16], {24'h0, tbl[i][15:8]}, tbl[i][7:0], 1'b0);
            if (tbl[i][24:0] == 25'h0_08_00_05)
                chk("mult_eff", 32'h1, {28'h0, mult_eff});
        end
        $display("test registers done");
        for (k = 0; k < 300 && vco_locked_in !== 1'b1; k++) @(posedge pclk);
        if (k == 300)
        begin
            num_errors++;
            final_report();
        end
        apb(1'b1, BW_OFS, 32'h80, 8'h00, 1'b0);
        apb(1'b0, BW_OFS, 32'h0, 8'hc0, 1'b0);
        apb(1'b0, CTRL_OFS, 32'h0, 8'h6f, 1'b0);
        apb(1'b0, CTRL_OFS, 32'h0, 8'h2f, 1'b0);
        apb(1'b1, CTRL_OFS, 32'ha0, 8'h00, 1'b0);
        hit <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("loop_irq", 32'h1, {31'h0, loop_irq});
        apb(1'b0, CTRL_OFS, 32'h0, 8'hef, 1'b0);
        chk("loop_irq", 32'h0, {31'h0, loop_irq});
        hit <= 1'b0;
        apb(1'b1, BW_OFS, 32'h0, 8'h00, 1'b0);
        apb(1'b0, CTRL_OFS, 32'h0, 8'h2f, 1'b0);
        $display("test lock flag done");
        apb(1'b1, CTRL_OFS, 32'h30, 8'h00, 1'b0);
        repeat (40) @(posedge pclk);
        meas("vco", 6);
        stop_in <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("base_clk", 32'h0, {31'h0, base_clk});
        stop_in <= 1'b0;
        apb(1'b0, CTRL_OFS, 32'h0, 8'h2f, 1'b0);
        repeat (40) @(posedge pclk);
        meas("xtal", 10);
        $display("test clock select done");
        repeat (3)
        begin
            ra = 8'h0c + 8'(($random(seed) & 7) * 4);
            apb(1'b1, ra, $random(seed), 8'h00, 1'b1);
            apb(1'b0, ra, 32'h0, 8'h00, 1'b1);
        end
        osc_enable_in <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("loop_enable", 32'h0, {31'h0, loop_enable});
        chk("osc_run", 32'h0, {31'h0, osc_run});
        $display("test unmapped and enable done");
        final_report();
    end
endmodule
